// ### ecrc_defines.svh
// reset encodings, emulation decode offsets and timing counts
`ifndef ECRC_DEFINES_SVH
`define ECRC_DEFINES_SVH

// pin-assignment field encodings
`define ECRC_PA_DISCRETE   2'h0
`define ECRC_PA_ALTERNATE  2'h1
`define ECRC_PA_CS8        2'h2
`define ECRC_PA_CS16       2'h3

// pin_assign_reg0 field positions (lsb of each 2-bit field)
`define ECRC_PA0_BOOT_LSB  0
`define ECRC_PA0_CS0_LSB   2
`define ECRC_PA0_CSM_LSB   4
`define ECRC_PA0_CSE_LSB   6
`define ECRC_PA0_CS3_LSB   8
`define ECRC_PA0_FC1_LSB   10
`define ECRC_PA0_CS5_LSB   12

// boot base register reset: base 0, block size code 1 Mbyte
`define ECRC_BOOT_BASE_RST 16'h0007
// boot option reset: async mode, both bytes, r/w, as strobe, 13 waits,
// supervisor/user, ipl any, external vector
`define ECRC_BOOT_OPT_RST  16'h7b70

// emulated port registers live in a fixed block of the register space
`define ECRC_PORT_BLK_MASK 24'hffffc0
`define ECRC_PORT_BLK_BASE 24'hfffa00

// port-emulation cycle length in clocks (no wait states)
`define ECRC_PORT_CYC_CLKS 3'h3
`define ECRC_WAIT_W        4
`endif

// ### ecrc_pkg.sv
// types shared by the emulation chip-select block
package ecrc_pkg;
  typedef enum logic [2:0] {
    ECRC_IDLE = 3'b001,
    ECRC_PORT = 3'b010,
    ECRC_ROM  = 3'b100
  } ecrc_state_t;

  typedef enum logic [2:0] {
    ECRC_MODE_SINGLE  = 3'b001,
    ECRC_MODE_PARTIAL = 3'b010,
    ECRC_MODE_FULL    = 3'b100
  } ecrc_busmode_t;
endpackage

// ### ecrc_wait_counter.sv
// wait-state counter used to time internal acknowledges
`include "ecrc_defines.svh"
module ecrc_wait_counter (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     start_i,
  input  wire logic                     abort_i,
  input  wire logic [`ECRC_WAIT_W-1:0]  count_i,
  output logic                          done_o
);
  logic [`ECRC_WAIT_W-1:0] cnt_r;
  logic [`ECRC_WAIT_W-1:0] cnt_nxt;
  logic                    run_r;
  logic                    run_nxt;
  logic                    done_r;
  logic                    done_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    done_nxt = 1'b0;
    if (abort_i)
    begin
      run_nxt = 1'b0;
    end
    else if (start_i)
    begin
      cnt_nxt = count_i;
      run_nxt = 1'b1;
    end
    else if (run_r)
    begin
      if (cnt_r == '0)
      begin
        run_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r  <= '0;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end
    else if (clk_en_i)
    begin
      cnt_r  <= cnt_nxt;
      run_r  <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
endmodule

// ### ecrc_emul_chipsel.sv
// emulation chip selects and reset-time chip-select pin configuration
// Overview of operation
// - port select asserts for emulated port data/direction/assign registers.
// - device gives no internal response to externally mapped port accesses.
// - port c data and port f registers stay internally accessible.
// - port select on strobe fall; acknowledge, no waits, three-clock access.
// - rom select asserts on valid access to masked rom addresses.
// - rom module does not acknowledge bus accesses in emulation mode.
// - emulated rom acknowledge after programmed wait-state count.
// - emulation selects have no base/option; assign reg 0 chooses function.
// - single-chip reset: all chip-select pins except boot are port c outputs.
// - partially expanded reset: all pins are chip selects.
// - full mode: data2 low gives request/fc pins; data10 low emulation selects.
// - boot port size latched from data0: low 8-bit, high 16-bit.
// - full mode: data bit n low makes that and lower pins address lines.
// - general select base and option registers reset to zero.
// - chip select enabled only by non-zero option byte field.
// - boot assignment field upper bit resets to one.
// - boot base address resets to zero.
// - boot option resets: 1M, async, both, r/w, strobe, 13 waits, ext vector.
// - with mirrored upper address bits boot block acts as 512 Kbyte.
// - assign field: 00 discrete, 01 alternate, 10 cs 8-bit, 11 cs 16-bit.
`include "ecrc_defines.svh"
module ecrc_emul_chipsel (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    clk_en_i,
  input  wire logic [15:0]             data_pin_i,
  input  wire logic                    bus_error_in_n_i,
  input  wire logic                    mode_single_i,
  input  wire logic                    mode_partial_i,
  input  wire logic                    address_strobe_n_i,
  input  wire logic [23:0]             addr_i,
  input  wire logic                    port_c_data_hit_i,
  input  wire logic                    port_f_hit_i,
  input  wire logic                    rom_present_i,
  input  wire logic                    rom_hit_i,
  input  wire logic [`ECRC_WAIT_W-1:0] rom_wait_i,
  input  wire logic                    upper_addr_mirror_i,
  input  wire logic [1:0]              opt_byte_field_i,
  input  wire logic                    pa0_wr_i,
  input  wire logic [15:0]             pa0_wdata_i,
  input  wire logic                    pa1_wr_i,
  input  wire logic [15:0]             pa1_wdata_i,
  output logic                         emul_mode_o,
  output logic                         port_emul_select_n_o,
  output logic                         rom_emul_select_n_o,
  output logic                         size_ack_o,
  output logic                         block_internal_resp_o,
  output logic                         rom_ack_block_o,
  output logic [15:0]                  pin_assign_reg0_o,
  output logic [15:0]                  pin_assign_reg1_o,
  output logic [15:0]                  boot_base_reg_o,
  output logic [15:0]                  boot_option_reg_o,
  output logic [15:0]                  gen_base_opt_o,
  output logic                         gen_select_en_o,
  output logic                         boot_eff_512k_o
);
  // pins are asynchronous to ref_clk_i: two flops each
  logic [15:0] data_s1_r;
  logic [15:0] data_s2_r;
  logic [3:0]  ctl_s1_r;
  logic [3:0]  ctl_s2_r;
  logic [1:0]  strap_done_r;
  logic [1:0]  strap_done_nxt;
  logic        emul_r;
  logic        emul_nxt;
  logic [15:0] pa0_r;
  logic [15:0] pa0_nxt;
  logic [15:0] pa1_r;
  logic [15:0] pa1_nxt;
  logic        strobe_d_r;
  logic        cse_n_r;
  logic        cse_n_nxt;
  logic        csm_n_r;
  logic        csm_n_nxt;
  logic        ack_r;
  logic        ack_nxt;
  logic        blk_r;
  logic        blk_nxt;
  logic [2:0]  cyc_r;
  logic [2:0]  cyc_nxt;
  logic        gen_en_r;
  logic        eff512_r;
  ecrc_pkg::ecrc_state_t   st_r;
  ecrc_pkg::ecrc_state_t   st_nxt;
  ecrc_pkg::ecrc_busmode_t mode;
  logic        strobe_low;
  logic        strobe_fall;
  logic        strobe_rise;
  logic        port_hit;
  logic        rom_done;

  // one 2-bit field from a reset strap level: high -> dflt, low -> alt
  function automatic logic [1:0] strap_field(input logic lvl, input logic [1:0] dflt,
                                             input logic [1:0] alt);
    strap_field = lvl ? dflt : alt;
  endfunction

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_s1_r <= 16'hffff;
      data_s2_r <= 16'hffff;
      ctl_s1_r  <= 4'hf;
      ctl_s2_r  <= 4'hf;
    end
    else if (clk_en_i)
    begin
      data_s1_r <= data_pin_i;
      data_s2_r <= data_s1_r;
      ctl_s1_r  <= {bus_error_in_n_i, mode_single_i, mode_partial_i, address_strobe_n_i};
      ctl_s2_r  <= ctl_s1_r;
    end
  end

  always_comb
  begin
    if (ctl_s2_r[2])
    begin
      mode = ecrc_pkg::ECRC_MODE_SINGLE;
    end
    else if (ctl_s2_r[1])
    begin
      mode = ecrc_pkg::ECRC_MODE_PARTIAL;
    end
    else
    begin
      mode = ecrc_pkg::ECRC_MODE_FULL;
    end
  end

  assign strobe_low  = !ctl_s2_r[0];
  assign strobe_fall = strobe_low && !strobe_d_r;
  assign strobe_rise = !strobe_low && strobe_d_r;
  // port c data and port f registers are decoded out before the block match
  assign port_hit = ((addr_i & `ECRC_PORT_BLK_MASK) == `ECRC_PORT_BLK_BASE)
                  && !port_c_data_hit_i && !port_f_hit_i;

  // straps are re-taken on each of the first three enabled edges after release;
  // only the third sees real pin levels, so emulation stays off until then
  always_comb
  begin
    strap_done_nxt = strap_done_r;
    emul_nxt       = emul_r;
    pa0_nxt        = pa0_r;
    pa1_nxt        = pa1_r;
    if (strap_done_r != 2'h3)
    begin
      strap_done_nxt = strap_done_r + 2'h1;
      emul_nxt = !data_s2_r[10] && ctl_s2_r[3] && !data_s2_r[1];
      pa0_nxt = 16'h0000;
      pa0_nxt[`ECRC_PA0_BOOT_LSB+1] = 1'b1;
      pa0_nxt[`ECRC_PA0_BOOT_LSB]   = data_s2_r[0];
      unique case (mode)
        ecrc_pkg::ECRC_MODE_SINGLE:
        begin
          // boot field is fixed hardware; all other pins port c
          pa0_nxt[13:2] = 12'h000;
          pa1_nxt       = 16'h0000;
        end
        ecrc_pkg::ECRC_MODE_PARTIAL:
        begin
          pa0_nxt[13:2] = 12'hfff;
          pa1_nxt       = 16'h03ff;
        end
        ecrc_pkg::ECRC_MODE_FULL:
        begin
          pa0_nxt[`ECRC_PA0_CS5_LSB+:2] = strap_field(data_s2_r[2], `ECRC_PA_CS16,
                                                      `ECRC_PA_ALTERNATE);
          pa0_nxt[`ECRC_PA0_FC1_LSB+:2] = strap_field(data_s2_r[2], `ECRC_PA_CS16,
                                                      `ECRC_PA_ALTERNATE);
          pa0_nxt[`ECRC_PA0_CS3_LSB+:2] = strap_field(data_s2_r[2], `ECRC_PA_CS16,
                                                      `ECRC_PA_ALTERNATE);
          pa0_nxt[`ECRC_PA0_CS0_LSB+:2] = strap_field(data_s2_r[2], `ECRC_PA_CS16,
                                                      `ECRC_PA_ALTERNATE);
          pa0_nxt[`ECRC_PA0_CSE_LSB+:2] = strap_field(data_s2_r[10], `ECRC_PA_ALTERNATE,
                                                      `ECRC_PA_CS16);
          pa0_nxt[`ECRC_PA0_CSM_LSB+:2] = strap_field(data_s2_r[10], `ECRC_PA_ALTERNATE,
                                                      `ECRC_PA_CS16);
          pa1_nxt = 16'h0000;
          for (int i = 0; i < 5; i++)
          begin
            // a low on data bit 3+i or any higher bit up to 7 forces addressing
            pa1_nxt[2*i+:2] = strap_field(&(data_s2_r[7:3] | ((5'h1 << i) - 5'h1)),
                                          `ECRC_PA_CS16, `ECRC_PA_ALTERNATE);
          end
        end
      endcase
    end
    else
    begin
      // only the selector sits here; the emulation selects own no base/option
      if (pa0_wr_i)
      begin
        pa0_nxt = {2'h0, pa0_wdata_i[13:2], 1'b1, pa0_wdata_i[0]};
      end
      if (pa1_wr_i)
      begin
        pa1_nxt = {6'h00, pa1_wdata_i[9:0]};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      strap_done_r <= 2'h0;
      emul_r       <= 1'b0;
      pa0_r        <= 16'h0002;
      pa1_r        <= 16'h0000;
    end
    else if (clk_en_i)
    begin
      strap_done_r <= strap_done_nxt;
      emul_r       <= emul_nxt;
      pa0_r        <= pa0_nxt;
      pa1_r        <= pa1_nxt;
    end
  end

  ecrc_wait_counter u_rom_wait (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .start_i   (st_r == ecrc_pkg::ECRC_IDLE && strobe_fall && emul_r &&
                rom_present_i && rom_hit_i && !port_hit),
    .abort_i   (strobe_rise),
    .count_i   (rom_wait_i),
    .done_o    (rom_done)
  );

  // emulation-select cycle sequencer
  always_comb
  begin
    st_nxt    = st_r;
    cse_n_nxt = cse_n_r;
    csm_n_nxt = csm_n_r;
    ack_nxt   = 1'b0;
    blk_nxt   = blk_r;
    cyc_nxt   = cyc_r;
    unique case (st_r)
      ecrc_pkg::ECRC_IDLE:
      begin
        if (strobe_fall && emul_r && port_hit)
        begin
          st_nxt    = ecrc_pkg::ECRC_PORT;
          cse_n_nxt = 1'b0;
          blk_nxt   = 1'b1;
          cyc_nxt   = 3'h1;
        end
        else if (strobe_fall && emul_r && rom_present_i && rom_hit_i)
        begin
          st_nxt    = ecrc_pkg::ECRC_ROM;
          csm_n_nxt = 1'b0;
        end
      end
      ecrc_pkg::ECRC_PORT:
      begin
        cyc_nxt = (cyc_r == 3'h7) ? cyc_r : cyc_r + 3'h1;
        // strobe fall is clock one; acknowledge lands for a three-clock access
        if (cyc_r == `ECRC_PORT_CYC_CLKS - 3'h2)
        begin
          ack_nxt = 1'b1;
        end
        if (strobe_rise)
        begin
          st_nxt    = ecrc_pkg::ECRC_IDLE;
          cse_n_nxt = 1'b1;
          blk_nxt   = 1'b0;
        end
      end
      ecrc_pkg::ECRC_ROM:
      begin
        ack_nxt = rom_done;
        if (strobe_rise)
        begin
          st_nxt    = ecrc_pkg::ECRC_IDLE;
          csm_n_nxt = 1'b1;
        end
      end
      default:
      begin
        st_nxt    = ecrc_pkg::ECRC_IDLE;
        cse_n_nxt = 1'b1;
        csm_n_nxt = 1'b1;
        blk_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r       <= ecrc_pkg::ECRC_IDLE;
      strobe_d_r <= 1'b0;
      cse_n_r    <= 1'b1;
      csm_n_r    <= 1'b1;
      ack_r      <= 1'b0;
      blk_r      <= 1'b0;
      cyc_r      <= 3'h0;
      gen_en_r   <= 1'b0;
      eff512_r   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_r       <= st_nxt;
      strobe_d_r <= strobe_low;
      cse_n_r    <= cse_n_nxt;
      csm_n_r    <= csm_n_nxt;
      ack_r      <= ack_nxt;
      blk_r      <= blk_nxt;
      cyc_r      <= cyc_nxt;
      gen_en_r   <= (opt_byte_field_i != 2'h0);
      eff512_r   <= upper_addr_mirror_i;
    end
  end

  assign emul_mode_o           = emul_r;
  assign port_emul_select_n_o  = cse_n_r;
  assign rom_emul_select_n_o   = csm_n_r;
  assign size_ack_o            = ack_r;
  assign block_internal_resp_o = blk_r;
  assign rom_ack_block_o       = emul_r;
  assign pin_assign_reg0_o     = pa0_r;
  assign pin_assign_reg1_o     = pa1_r;
  // constant reset images; software-written copies live outside this block
  assign boot_base_reg_o       = `ECRC_BOOT_BASE_RST;
  assign boot_option_reg_o     = `ECRC_BOOT_OPT_RST;
  assign gen_base_opt_o        = 16'h0000;
  assign gen_select_en_o       = gen_en_r;
  assign boot_eff_512k_o       = eff512_r;
endmodule

// ### ecrc_chipsel_sva.sv
// concurrent checks on the emulation chip-select block ports
`include "ecrc_defines.svh"
module ecrc_chipsel_sva (
  input wire logic                    ref_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    address_strobe_n_i,
  input wire logic [23:0]             addr_i,
  input wire logic                    port_c_data_hit_i,
  input wire logic                    port_f_hit_i,
  input wire logic                    rom_present_i,
  input wire logic                    rom_hit_i,
  input wire logic [`ECRC_WAIT_W-1:0] rom_wait_i,
  input wire logic [1:0]              opt_byte_field_i,
  input wire logic                    emul_mode_o,
  input wire logic                    port_emul_select_n_o,
  input wire logic                    rom_emul_select_n_o,
  input wire logic                    size_ack_o,
  input wire logic                    block_internal_resp_o,
  input wire logic                    rom_ack_block_o,
  input wire logic [15:0]             pin_assign_reg0_o,
  input wire logic [15:0]             boot_base_reg_o,
  input wire logic [15:0]             boot_option_reg_o,
  input wire logic [15:0]             gen_base_opt_o,
  input wire logic                    gen_select_en_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [5:0] rom_cnt_r;
  logic [5:0] rom_cnt_nxt;
  logic       port_hit;
  logic       rom_req;
  assign port_hit = emul_mode_o && ((addr_i & `ECRC_PORT_BLK_MASK) == `ECRC_PORT_BLK_BASE)
                    && !port_c_data_hit_i && !port_f_hit_i;
  assign rom_req = emul_mode_o && rom_present_i && rom_hit_i && !port_hit;
  // clocks spent with the rom select low, for the wait-state figure
  always_comb
  begin
    rom_cnt_nxt = rom_emul_select_n_o ? 6'h0 : rom_cnt_r + 6'h1;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rom_cnt_r <= 6'h0;
    else
      rom_cnt_r <= rom_cnt_nxt;
  end
  a_port_sel_start: assert property ($fell(address_strobe_n_i) && port_hit |->
    ##[2:3] !port_emul_select_n_o) else $error("port select missing");
  a_port_ack_next: assert property ($fell(port_emul_select_n_o) |=> size_ack_o)
    else $error("port ack not one clock after select");
  a_port_no_resp: assert property (!port_emul_select_n_o |-> block_internal_resp_o)
    else $error("internal response during port cycle");
  a_port_excluded: assert property ($fell(port_emul_select_n_o) |->
    !port_c_data_hit_i && !port_f_hit_i) else $error("select on internal port");
  a_rom_sel_start: assert property ($fell(address_strobe_n_i) && rom_req |->
    ##[2:3] !rom_emul_select_n_o) else $error("rom select missing");
  a_rom_wait_count: assert property (!rom_emul_select_n_o |->
    size_ack_o == (rom_cnt_r == {2'h0, rom_wait_i} + 6'h2)) else $error("rom ack timing");
  a_rom_ack_off: assert property (rom_ack_block_o == emul_mode_o)
    else $error("rom ack block wrong");
  a_sel_need_emul: assert property (!emul_mode_o |->
    port_emul_select_n_o && rom_emul_select_n_o) else $error("select outside emulator mode");
  a_strobe_negates: assert property ($rose(address_strobe_n_i) |->
    ##[1:3] (port_emul_select_n_o && rom_emul_select_n_o)) else $error("select held");
  a_boot_reg_values: assert property (boot_base_reg_o == `ECRC_BOOT_BASE_RST &&
    boot_option_reg_o == `ECRC_BOOT_OPT_RST && gen_base_opt_o == 16'h0)
    else $error("base or option value wrong");
  a_boot_msb_set: assert property (pin_assign_reg0_o[1] && pin_assign_reg0_o[15:14] == 2'h0)
    else $error("boot field msb clear");
  a_gen_enable: assert property (1'b1 |=>
    gen_select_en_o == ($past(opt_byte_field_i) != 2'h0)) else $error("enable mismatch");
  c_port_cycle: cover property (!port_emul_select_n_o && size_ack_o);
  c_rom_cycle: cover property (!rom_emul_select_n_o && size_ack_o);
  c_emul_mode: cover property ($rose(emul_mode_o));
endmodule
bind ecrc_emul_chipsel ecrc_chipsel_sva u_sva (.ref_clk_i, .rst_n_i, .address_strobe_n_i,
  .addr_i, .port_c_data_hit_i, .port_f_hit_i, .rom_present_i, .rom_hit_i, .rom_wait_i,
  .opt_byte_field_i, .emul_mode_o, .port_emul_select_n_o, .rom_emul_select_n_o, .size_ack_o,
  .block_internal_resp_o, .rom_ack_block_o, .pin_assign_reg0_o, .boot_base_reg_o,
  .boot_option_reg_o, .gen_base_opt_o, .gen_select_en_o);

// ### ecrc_pru_model.sv
// external strap driver and port replacement unit stand-in
module ecrc_pru_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] strap_i,
  input  wire logic        bus_error_in_cfg_i,
  input  wire logic        port_sel_n_i,
  output logic [15:0]      data_pin_o,
  output logic             bus_error_n_o,
  output logic [7:0]       hit_cnt_o
);
  logic [2:0] hold_r;
  logic [2:0] hold_nxt;
  logic       sel_r;
  logic [7:0] hit_nxt;
  // straps held through reset and a few clocks past, then pull-ups win
  assign data_pin_o = (hold_r != 3'h4) ? strap_i : 16'hffff;
  assign bus_error_n_o = (hold_r != 3'h4) ? bus_error_in_cfg_i : 1'b1;
  always_comb
  begin
    hold_nxt = (hold_r == 3'h4) ? hold_r : hold_r + 3'h1;
    hit_nxt = (sel_r && !port_sel_n_i) ? hit_cnt_o + 8'h1 : hit_cnt_o;
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_r <= 3'h0;
      sel_r <= 1'b1;
      hit_cnt_o <= 8'h0;
    end
    else
    begin
      hold_r <= hold_nxt;
      sel_r <= port_sel_n_i;
      hit_cnt_o <= hit_nxt;
    end
  end
endmodule

// ### tb_emul_chipsel_reset_config.sv
// self-checking bench for the emulation chip-select block
module tb_emul_chipsel_reset_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        as_n = 1'b1;
  logic        pc = 1'b0;
  logic        pf = 1'b0;
  logic        rp = 1'b0;
  logic        rh = 1'b0;
  logic        mirror = 1'b0;
  logic        single = 1'b0;
  logic        partial = 1'b0;
  logic        wr = 1'b0;
  logic        bus_error_in_cfg = 1'b1;
  logic [23:0] addr = 24'h0;
  logic [3:0]  wt = 4'h0;
  logic [1:0]  opt = 2'h0;
  logic [15:0] strap = 16'hffff;
  logic [15:0] wd = 16'h0;
  logic        emul, psel_n, rsel_n, ack, blk, gen_en, eff512, bus_error_in_n;
  logic [15:0] pa0, pa1, dpin;
  logic [7:0]  hits;
  int          fail_count = 0;
  int          n_checks = 0;
  int          seed = 32'hd24bb263;
  int          i;
  always #5 clk = ~clk;
  ecrc_emul_chipsel dut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
    .data_pin_i(dpin), .bus_error_in_n_i(bus_error_in_n), .mode_single_i(single),
    .mode_partial_i(partial), .address_strobe_n_i(as_n), .addr_i(addr),
    .port_c_data_hit_i(pc), .port_f_hit_i(pf), .rom_present_i(rp), .rom_hit_i(rh),
    .rom_wait_i(wt), .upper_addr_mirror_i(mirror), .opt_byte_field_i(opt),
    .pa0_wr_i(wr), .pa0_wdata_i(wd), .pa1_wr_i(wr), .pa1_wdata_i(wd),
    .emul_mode_o(emul), .port_emul_select_n_o(psel_n), .rom_emul_select_n_o(rsel_n),
    .size_ack_o(ack), .block_internal_resp_o(blk), .rom_ack_block_o(),
    .pin_assign_reg0_o(pa0), .pin_assign_reg1_o(pa1), .boot_base_reg_o(),
    .boot_option_reg_o(), .gen_base_opt_o(), .gen_select_en_o(gen_en),
    .boot_eff_512k_o(eff512));
  ecrc_pru_model u_pru (.ref_clk_i(clk), .rst_n_i(rst_n), .strap_i(strap),
    .bus_error_in_cfg_i(bus_error_in_cfg), .port_sel_n_i(psel_n), .data_pin_o(dpin),
    .bus_error_n_o(bus_error_in_n), .hit_cnt_o(hits));
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] exp_pa1(input logic [15:0] d);
    int k;
    exp_pa1 = 16'h0;
    // a low strap turns its pin and every lower one into address
    for (k = 0; k < 5; k++)
      exp_pa1[2*k +: 2] = (&(d[7:3] | ((5'h1 << k) - 5'h1))) ? 2'h3 : 2'h1;
  endfunction
  task automatic do_reset(input logic [15:0] st, input logic be, input int md);
    logic [1:0] f2;
    logic [1:0] f10;
    f2 = st[2] ? 2'h3 : 2'h1;
    f10 = st[10] ? 2'h1 : 2'h3;
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= st;
    bus_error_in_cfg <= be;
    single <= (md == 1);
    partial <= (md == 2);
    opt <= 2'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    if (md == 0)
    begin
      chk("emul", emul, !st[10] && be && !st[1]);
      chk("pa1", pa1, exp_pa1(st));
      chk("pa0", pa0, {2'h0, f2, f2, f2, f10, f10, f2, 1'b1, st[0]});
    end
    else if (md == 1)
      chk("pa_single", {pa1, pa0 & 16'hfffc}, 32'h0);
    else
      chk("pa_part", {pa1, pa0 & 16'hfffc}, {16'h03ff, 16'h3ffc});
  endtask
  // kind 0 expects no select, 1 a port cycle, 2 a rom cycle
  task automatic bus(input logic [23:0] a, input logic [3:0] c, input logic [3:0] w,
                     input int kind);
    int n;
    int ts;
    int ta;
    int h;
    ts = -1;
    ta = -1;
    h = hits;
    @(posedge clk);
    addr <= a;
    {pc, pf, rh, rp} <= c;
    wt <= w;
    opt <= 2'($random(seed));
    as_n <= 1'b0;
    for (n = 0; n < 30; n++)
    begin
      @(negedge clk);
      if (ts < 0 && (psel_n === 1'b0 || rsel_n === 1'b0))
      begin
        ts = n;
        chk("blk", blk, kind == 1);
      end
      if (ack === 1'b1)
        ta = n;
    end
    chk("gen_en", gen_en, opt != 2'h0);
    chk("start", ts, kind == 0 ? -1 : 3);
    chk("ack", ta - ts, kind == 1 ? 1 : kind == 2 ? w + 2 : 0);
    chk("hits", hits - h, kind == 1);
    @(posedge clk);
    as_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk("negate", {psel_n, rsel_n, blk}, 3'b110);
  endtask
  initial
  begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    do_reset(16'hffff, 1'b1, 0);
    do_reset(16'hfbfd, 1'b0, 0);
    for (i = 0; i < 15; i++)
      do_reset(16'($random(seed)), 1'($random(seed)), i % 3);
    do_reset(16'hfbfd, 1'b1, 0);
    foreach (wd[j])
      if (j < 3)
        bus(24'hfffa00 + {18'h0, j == 0 ? 6'h0 : j == 1 ? 6'h3f : 6'h15}, 4'h0, 4'h0, 1);
    bus(24'hfffa01, 4'h8, 4'h0, 0);
    bus(24'hfffa21, 4'h4, 4'h0, 0);
    bus(24'hfffa40, 4'h0, 4'h0, 0);
    bus(24'h001000, 4'h3, 4'h0, 2);
    bus(24'h003000, 4'h3, 4'h7, 2);
    bus(24'h004000, 4'h3, 4'hf, 2);
    bus(24'h004000, 4'h2, 4'h1, 0);
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      wr <= 1'b1;
      wd <= 16'($random(seed));
      mirror <= i[0];
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
      chk("pa0_wr", pa0, (wd & 16'h3fff) | 16'h0002);
      chk("pa1_wr", pa1, wd & 16'h03ff);
      repeat (3) @(negedge clk);
      chk("eff512", eff512, mirror);
    end
    do_reset(16'hffff, 1'b1, 0);
    bus(24'hfffa02, 4'h0, 4'h0, 0);
    bus(24'h001000, 4'h3, 4'h2, 0);
    stop_test();
  end
endmodule
